// ==== hdl/dlsc_top.sv ====
`timescale 1ns/10ps
module dlsc_top
    import dlsc_pkg::*;
#(
    parameter int OFF_CYCLES = OC_OFF_CYC,
    parameter int ON_CYCLES = OC_ON_CYC,
    parameter int BC_OFF_CYCLES = BC_OFF_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic overTemp,
    input wire dlscChanIn_t [CHANNELS-1:0] chanIn,
    output dlscChanOut_t [CHANNELS-1:0] chanOut,
    output logic boostClock,
    output logic fault_n
);
    localparam logic [TIMER_W-1:0] OFF_LAST = TIMER_W'(OFF_CYCLES - 1);
    localparam logic [TIMER_W-1:0] ON_LAST = TIMER_W'(ON_CYCLES - 1);
    localparam logic [TIMER_W-1:0] BCOFF_LAST = TIMER_W'(BC_OFF_CYCLES - 1);
    localparam logic [TIMER_W-1:0] DELAY_LAST = TIMER_W'(OC_DELAY_CYC - 1);
    localparam logic [TIMER_W-1:0] BCWAIT_LAST = TIMER_W'(BC_WAIT_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BOOST_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(BOOST_HALF);
    localparam logic [TCNT_W-1:0] TONE_LAST = TCNT_W'(TONE_HALF_BOOSTS - 1);

    typedef struct packed {
        dlscCtrl_t ctrl;
        dlscOcState_t ocState;
        dlscBcState_t bcState;
        logic [TIMER_W-1:0] ocTimer;
        logic [TIMER_W-1:0] bcTimer;
        logic overloadFlag;
        logic backCurrentFlag;
        dlscChanOut_t out;
    } dlscChan_t;

    typedef struct packed {
        dlscChan_t [CHANNELS-1:0] ch;
        logic [DIV_W-1:0] divCnt;
        logic [TCNT_W-1:0] toneCnt;
        logic toneLevel;
        logic boostClk;
        logic thermal;
        logic faultN;
        logic [31:0] rdata;
        logic slverr;
    } dlscState_t;

    localparam dlscChanOut_t OUT_RESET = '{
        powerEnable: 1'b0,
        boostBlock: 1'b1,
        voltageCode: 2'b00,
        limitSel: 3'b000,
        staticLimitMode: 1'b0,
        currentLimitOn: 1'b0,
        toneOut: 1'b0,
        thresholdTx: 1'b0,
        toneDetectOut: 1'b0,
        toneDetectOe_n: 1'b1,
        txIndicatorOut: 1'b0,
        txIndicatorOe_n: 1'b1
    };

    dlscState_t s;
    dlscState_t next_s;
    dlscStatus_t status;
    logic setupPhase;
    logic writeAccess;
    logic addrHit;

    assign setupPhase = psel & ~penable;
    assign writeAccess = psel & penable & pwrite;
    assign pready = psel & penable;
    assign prdata = s.rdata;
    assign pslverr = s.slverr & psel & penable;
    assign boostClock = s.boostClk;
    assign fault_n = s.faultN;
    assign addrHit = (paddr == ADDR_CTRL_CH1) | (paddr == ADDR_CTRL_CH2)
        | (paddr == ADDR_STATUS);

    always_comb begin
        status.thermal = s.thermal;
        status.overloadCh1 = s.ch[0].overloadFlag;
        status.backCurrentCh1 = s.ch[0].backCurrentFlag;
        status.overloadCh2 = s.ch[1].overloadFlag;
        status.backCurrentCh2 = s.ch[1].backCurrentFlag;
        status.faultN = s.faultN;
    end

    always_comb begin
        logic enabled;
        logic highSel;
        logic levelBit;
        logic anyFault;
        dlscCtrl_t c;
        enabled = 1'b0;
        highSel = 1'b0;
        levelBit = 1'b0;
        anyFault = 1'b0;
        c = '0;
        next_s = s;

        // converter clock and tone from one divider
        if (s.divCnt == DIV_LAST) begin
            next_s.divCnt = '0;
            if (s.toneCnt == TONE_LAST) begin
                next_s.toneCnt = '0;
                next_s.toneLevel = ~s.toneLevel;
            end else begin
                next_s.toneCnt = s.toneCnt + 1'b1;
            end
        end else begin
            next_s.divCnt = s.divCnt + 1'b1;
        end
        next_s.boostClk = (s.divCnt < DIV_HALF);

        // comparator already carries the 150/130 hysteresis
        next_s.thermal = overTemp;

        // setup cycle latches read data so prdata is a flop
        if (setupPhase) begin
            next_s.slverr = ~addrHit;
            case (paddr)
                ADDR_CTRL_CH1: next_s.rdata = 32'(s.ch[0].ctrl);
                ADDR_CTRL_CH2: next_s.rdata = 32'(s.ch[1].ctrl);
                ADDR_STATUS: next_s.rdata = 32'(status);
                default: next_s.rdata = 32'h00000000;
            endcase
        end

        for (int i = 0; i < CHANNELS; i++) begin
            if (writeAccess && paddr == (i == 0 ? ADDR_CTRL_CH1
                    : ADDR_CTRL_CH2)) begin
                next_s.ch[i].ctrl = pwdata[CTRL_W-1:0];
            end
            c = s.ch[i].ctrl;
            enabled = c.outputEnable & ~s.thermal;

            // overcurrent protection
            if (!enabled) begin
                next_s.ch[i].ocState = OC_NORMAL;
                next_s.ch[i].ocTimer = '0;
                next_s.ch[i].overloadFlag = 1'b0;
            end else if (c.staticLimitMode) begin
                // limited but never shut off
                next_s.ch[i].ocState = OC_NORMAL;
                next_s.ch[i].ocTimer = '0;
                next_s.ch[i].overloadFlag =
                    chanIn[i].overloadDetect;
            end else begin
                case (s.ch[i].ocState)
                    OC_NORMAL: begin
                        next_s.ch[i].overloadFlag = 1'b0;
                        if (chanIn[i].overloadDetect) begin
                            next_s.ch[i].ocState = OC_DELAY;
                            next_s.ch[i].ocTimer = '0;
                        end
                    end
                    OC_DELAY: begin
                        if (!chanIn[i].overloadDetect &&
                                !s.ch[i].overloadFlag) begin
                            next_s.ch[i].ocState = OC_NORMAL;
                        end else if (s.ch[i].ocTimer == DELAY_LAST) begin
                            next_s.ch[i].ocState = OC_OFF;
                            next_s.ch[i].ocTimer = '0;
                            next_s.ch[i].overloadFlag = 1'b1;
                        end else begin
                            next_s.ch[i].ocTimer = s.ch[i].ocTimer + 1'b1;
                        end
                    end
                    OC_OFF: begin
                        if (s.ch[i].ocTimer == OFF_LAST) begin
                            next_s.ch[i].ocState = OC_ON;
                            next_s.ch[i].ocTimer = '0;
                        end else begin
                            next_s.ch[i].ocTimer = s.ch[i].ocTimer + 1'b1;
                        end
                    end
                    OC_ON: begin
                        if (chanIn[i].overloadDetect) begin
                            next_s.ch[i].ocState = OC_OFF;
                            next_s.ch[i].ocTimer = '0;
                        end else if (s.ch[i].ocTimer == ON_LAST) begin
                            next_s.ch[i].ocState = OC_NORMAL;
                            next_s.ch[i].ocTimer = '0;
                            next_s.ch[i].overloadFlag = 1'b0;
                        end else begin
                            next_s.ch[i].ocTimer = s.ch[i].ocTimer + 1'b1;
                        end
                    end
                    default: begin
                        next_s.ch[i].ocState = OC_NORMAL;
                        next_s.ch[i].ocTimer = '0;
                    end
                endcase
            end

            // back-current protection
            if (!enabled) begin
                next_s.ch[i].bcState = BC_NORMAL;
                next_s.ch[i].bcTimer = '0;
                next_s.ch[i].backCurrentFlag = 1'b0;
            end else begin
                case (s.ch[i].bcState)
                    BC_NORMAL: begin
                        next_s.ch[i].backCurrentFlag = 1'b0;
                        if (chanIn[i].backCurrentDetect) begin
                            next_s.ch[i].bcState = BC_WAIT;
                            next_s.ch[i].bcTimer = '0;
                        end
                    end
                    BC_WAIT: begin
                        if (!chanIn[i].backCurrentDetect) begin
                            next_s.ch[i].bcState = BC_NORMAL;
                            next_s.ch[i].backCurrentFlag = 1'b0;
                        end else if (s.ch[i].bcTimer == BCWAIT_LAST) begin
                            next_s.ch[i].bcState = BC_OFF;
                            next_s.ch[i].bcTimer = '0;
                            next_s.ch[i].backCurrentFlag = 1'b1;
                        end else begin
                            next_s.ch[i].bcTimer = s.ch[i].bcTimer + 1'b1;
                        end
                    end
                    BC_OFF: begin
                        // flag kept across retries until a clean probe
                        if (s.ch[i].bcTimer == BCOFF_LAST) begin
                            next_s.ch[i].bcState = BC_WAIT;
                            next_s.ch[i].bcTimer = '0;
                        end else begin
                            next_s.ch[i].bcTimer = s.ch[i].bcTimer + 1'b1;
                        end
                    end
                    default: begin
                        next_s.ch[i].bcState = BC_NORMAL;
                        next_s.ch[i].bcTimer = '0;
                    end
                endcase
            end

            // registered pin outputs
            next_s.ch[i].out.powerEnable = enabled
                & (s.ch[i].ocState != OC_OFF)
                & (s.ch[i].bcState != BC_OFF);
            next_s.ch[i].out.boostBlock =
                ~next_s.ch[i].out.powerEnable;
            highSel = c.pinSelectDisable ? c.highRangeBit
                : chanIn[i].rangeSelectPin;
            levelBit = c.pinSelectDisable ? c.lowRangeBit
                : (highSel ? c.highRangeBit : c.lowRangeBit);
            next_s.ch[i].out.voltageCode = {highSel, levelBit};
            next_s.ch[i].out.limitSel = c.limitSel;
            next_s.ch[i].out.staticLimitMode = c.staticLimitMode;
            next_s.ch[i].out.currentLimitOn = c.staticLimitMode
                | (s.ch[i].ocState == OC_ON);
            if (c.toneEnable) begin
                next_s.ch[i].out.toneOut = s.toneLevel;
            end else if (c.extToneSelect) begin
                next_s.ch[i].out.toneOut = chanIn[i].toneModPin;
            end else begin
                next_s.ch[i].out.toneOut =
                    chanIn[i].toneModPin & s.toneLevel;
            end
            if (!next_s.ch[i].out.powerEnable) begin
                next_s.ch[i].out.toneOut = 1'b0;
            end
            // pin reads back the driven level when transmit mode is set
            next_s.ch[i].out.thresholdTx =
                chanIn[i].txIndicatorPin;
            next_s.ch[i].out.toneDetectOut = 1'b0;
            next_s.ch[i].out.toneDetectOe_n =
                ~chanIn[i].detectorIn;
            next_s.ch[i].out.txIndicatorOut = 1'b1;
            next_s.ch[i].out.txIndicatorOe_n = ~c.txModeBit;

            anyFault = anyFault | s.ch[i].overloadFlag
                | s.ch[i].backCurrentFlag;
        end

        next_s.faultN = ~(anyFault | s.thermal
            | (~s.ch[0].ctrl.outputEnable
            & ~s.ch[1].ctrl.outputEnable));
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
            // all control bits and flags come up cleared
            for (int i = 0; i < CHANNELS; i++) begin
                s.ch[i].ctrl <= CTRL_RESET;
                s.ch[i].ocState <= OC_NORMAL;
                s.ch[i].bcState <= BC_NORMAL;
                s.ch[i].overloadFlag <= 1'b0;
                s.ch[i].backCurrentFlag <= 1'b0;
                s.ch[i].out <= OUT_RESET;
            end
        end else begin
            s <= next_s;
        end
    end

    assign chanOut[0] = s.ch[0].out;
    assign chanOut[1] = s.ch[1].out;
endmodule

// ==== hdl/dlsc_pkg.sv ====
// Behaviour
// - 22kHz tone, converter clock twenty times it
// - both bits low: pin gates internal tone
// - tone-enable high: continuous tone, pin ignored
// - select bit high: pin tone passed through
// - detect output pulled low while tone present
// - transmit-indicator level picks detector threshold
// - enable low disables that channel's power block
// - pin-disable set: range bits alone pick voltage
// - pin-disable clear: pin picks range, bits pick level
// - dynamic mode: three bits pick five thresholds
// - dynamic overload: after 23us, off 900ms, flag
// - retry on 20ms; clean on-time clears flag
// - static mode: flag follows overload, no shutoff
// - flags low after power-on soft-start
// - back current over 100us: off 5ms, flag, repeat
// - over-temperature: all off, flag until cooled
// - fault low on faults or both enables low
// - all control bits cleared at power-up
// - transmit-mode bit drives indicator pin high
package dlsc_pkg;
    localparam int CHANNELS = 2;
    localparam int CLK_HZ = 25000000;
    localparam int CLK_KHZ = 25000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int TONE_HZ = 22000;
    localparam int BOOST_PER_TONE = 20;
    localparam int BOOST_DIV = CLK_HZ / (TONE_HZ * BOOST_PER_TONE);
    localparam int BOOST_HALF = BOOST_DIV / 2;
    localparam int TONE_HALF_BOOSTS = BOOST_PER_TONE / 2;
    localparam int OC_DELAY_NS = 23000;
    localparam int OC_DELAY_CYC =
        (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_OFF_MS = 900;
    localparam int OC_OFF_CYC = OC_OFF_MS * CLK_KHZ;
    localparam int OC_ON_MS = 20;
    localparam int OC_ON_CYC = OC_ON_MS * CLK_KHZ;
    localparam int BC_WAIT_NS = 100000;
    localparam int BC_WAIT_CYC =
        (BC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BC_OFF_MS = 5;
    localparam int BC_OFF_CYC = BC_OFF_MS * CLK_KHZ;
    localparam int TIMER_W = 25;
    localparam int DIV_W = 6;
    localparam int TCNT_W = 4;

    localparam logic [7:0] ADDR_CTRL_CH1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL_CH2 = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

    typedef struct packed {
        logic [2:0] limitSel;       // range, hi, lo
        logic staticLimitMode;
        logic lowRangeBit;
        logic highRangeBit;
        logic pinSelectDisable;
        logic txModeBit;
        logic extToneSelect;
        logic toneEnable;
        logic outputEnable;
    } dlscCtrl_t;

    typedef struct packed {
        logic faultN;
        logic backCurrentCh2;
        logic overloadCh2;
        logic backCurrentCh1;
        logic overloadCh1;
        logic thermal;
    } dlscStatus_t;

    typedef enum logic [1:0] {
        OC_NORMAL = 2'b00,
        OC_DELAY = 2'b01,
        OC_OFF = 2'b11,
        OC_ON = 2'b10
    } dlscOcState_t;

    typedef enum logic [1:0] {
        BC_NORMAL = 2'b00,
        BC_WAIT = 2'b01,
        BC_OFF = 2'b11
    } dlscBcState_t;

    typedef struct packed {
        logic toneModPin;
        logic rangeSelectPin;
        logic detectorIn;
        logic txIndicatorPin;
        logic overloadDetect;
        logic backCurrentDetect;
    } dlscChanIn_t;

    typedef struct packed {
        logic powerEnable;
        logic boostBlock;
        logic [1:0] voltageCode;
        logic [2:0] limitSel;
        logic staticLimitMode;
        logic currentLimitOn;
        logic toneOut;
        logic thresholdTx;
        logic toneDetectOut;
        logic toneDetectOe_n;
        logic txIndicatorOut;
        logic txIndicatorOe_n;
    } dlscChanOut_t;
endpackage

// ==== verif/dlsc_lnb_model.sv ====
`timescale 1ns/10ps
module dlsc_lnb_model
    import dlsc_pkg::*;
(
    input wire logic clock,
    input wire dlscChanOut_t [CHANNELS-1:0] chanOut,
    input wire logic [CHANNELS-1:0] shortCmd,
    input wire logic [CHANNELS-1:0] backfeedCmd,
    output logic [CHANNELS-1:0] overload = '0,
    output logic [CHANNELS-1:0] backCurrent = '0,
    output logic [CHANNELS-1:0] toneSeen = '0
);
    // a shorted or back-fed cable only shows current while powered
    always @(posedge clock) begin
        for (int i = 0; i < CHANNELS; i++) begin
            overload[i] <= shortCmd[i] & chanOut[i].powerEnable;
            backCurrent[i] <= backfeedCmd[i] & chanOut[i].powerEnable;
            toneSeen[i] <= chanOut[i].toneOut;
        end
    end
endmodule

// ==== verif/dlsc_props.sv ====
`timescale 1ns/10ps
module dlsc_props
    import dlsc_pkg::*;
#(
    parameter int OFF_CYCLES = OC_OFF_CYC,
    parameter int ON_CYCLES = OC_ON_CYC,
    parameter int BC_OFF_CYCLES = BC_OFF_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic overTemp,
    input wire dlscChanIn_t [CHANNELS-1:0] chanIn,
    input wire dlscChanOut_t [CHANNELS-1:0] chanOut,
    input wire logic boostClock,
    input wire logic fault_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // cycles since the boost clock last changed
    logic [7:0] bCnt;
    logic bSeen;
    always_ff @(posedge clock) begin
        if (reset) begin
            bCnt <= 8'h00;
            bSeen <= 1'b0;
        end else if ($changed(boostClock)) begin
            bCnt <= 8'h00;
            bSeen <= 1'b1;
        end else begin
            bCnt <= bCnt + 8'h01;
        end
    end
    a_boost_half: assert property ($changed(boostClock) && bSeen
        |-> bCnt == BOOST_HALF - 1) else $error("boost half period");
    a_boost_blk: assert property (chanOut[0].boostBlock
        != chanOut[0].powerEnable) else $error("boost block");
    a_fault_temp: assert property (overTemp
        |-> ##[1:3] !fault_n) else $error("fault on heat");
    a_thermal_off: assert property (overTemp |-> ##[1:3]
        !chanOut[0].powerEnable && !chanOut[1].powerEnable)
        else $error("thermal off");
    a_tx_drive: assert property (!chanOut[1].txIndicatorOe_n
        |-> chanOut[1].txIndicatorOut) else $error("tx drive");
    a_detect_on: assert property (chanIn[0].detectorIn |=>
        !chanOut[0].toneDetectOe_n && !chanOut[0].toneDetectOut)
        else $error("detect on");
    a_detect_off: assert property (!chanIn[1].detectorIn
        |=> chanOut[1].toneDetectOe_n) else $error("detect off");
    a_thresh_sel: assert property (1'b1 |=> chanOut[0].thresholdTx
        == $past(chanIn[0].txIndicatorPin)) else $error("threshold");
    c_heat: cover property (overTemp ##2 !fault_n);
    c_ol_off: cover property ($fell(chanOut[0].powerEnable));
    c_tx: cover property (!chanOut[1].txIndicatorOe_n);
endmodule
bind dlsc_top dlsc_props #(.OFF_CYCLES(OFF_CYCLES), .ON_CYCLES(ON_CYCLES),
    .BC_OFF_CYCLES(BC_OFF_CYCLES)) props (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overTemp(overTemp), .chanIn(chanIn), .chanOut(chanOut),
    .boostClock(boostClock), .fault_n(fault_n));

// ==== verif/dlsc_top_bench.sv ====
`timescale 1ns/10ps
module dlsc_top_bench
    import dlsc_pkg::*;
;
    logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic overTemp = 0, pready, pslverr, boostClock, fault_n, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdq;
    logic [CHANNELS-1:0] modPin = '0, selPin = '0, txExt = '0;
    logic [CHANNELS-1:0] shortCmd = '0, backfeedCmd = '0;
    logic [CHANNELS-1:0] overload, backCurrent, toneSeen;
    dlscChanIn_t [CHANNELS-1:0] chanIn;
    dlscChanOut_t [CHANNELS-1:0] chanOut;
    dlscCtrl_t cfg;
    int n_mismatch = 0, checks = 0, n, t;
    always #20 clock = ~clock;
    // indicator pin: device drives it when enabled, else the bench does
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            chanIn[i] = {modPin[i], selPin[i], toneSeen[i],
                chanOut[i].txIndicatorOe_n ? txExt[i] :
                chanOut[i].txIndicatorOut, overload[i], backCurrent[i]};
        end
    end
    dlsc_top #(.OFF_CYCLES(200), .ON_CYCLES(50), .BC_OFF_CYCLES(30)) dut (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .overTemp(overTemp),
        .chanIn(chanIn), .chanOut(chanOut), .boostClock(boostClock),
        .fault_n(fault_n));
    dlsc_lnb_model lnb (.clock(clock), .chanOut(chanOut),
        .shortCmd(shortCmd), .backfeedCmd(backfeedCmd), .overload(overload),
        .backCurrent(backCurrent), .toneSeen(toneSeen));
    task automatic end_sim();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            end_sim();
        end
        rdq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following setup never reassigns psel at once
        @(posedge clock);
    endtask
    task automatic tog(input int c, output int cnt);
        logic last;
        cnt = 0;
        last = chanOut[c].toneOut;
        repeat (1200) begin
            @(posedge clock);
            if (chanOut[c].toneOut !== last) cnt++;
            last = chanOut[c].toneOut;
        end
    endtask
    function automatic logic [1:0] expv(dlscCtrl_t k, logic pin);
        if (k.pinSelectDisable) return {k.highRangeBit, k.lowRangeBit};
        return pin ? {1'b1, k.highRangeBit} : {1'b0, k.lowRangeBit};
    endfunction
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        end_sim();
    end
    initial begin
        void'($urandom(77517));
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        apb(0, ADDR_CTRL_CH1, 0); chk("ctrl1 rst", rdq, 0);
        apb(0, ADDR_CTRL_CH2, 0); chk("ctrl2 rst", rdq, 0);
        apb(0, ADDR_STATUS, 0); chk("status rst", rdq, 0);
        chk("fault both off", fault_n, 0);
        apb(0, 8'h0C, 0); chk("unmapped err", rerr, 1);
        // random settings on both channels, select pin and tx level
        for (int i = 0; i < 24; i++) begin
            t = i % 2;
            cfg = dlscCtrl_t'(CTRL_W'($urandom));
            apb(1, t ? ADDR_CTRL_CH2 : ADDR_CTRL_CH1, 32'(cfg));
            selPin[t] <= 1'($urandom);
            txExt[t] <= 1'($urandom);
            repeat (3) @(posedge clock);
            chk("volt", chanOut[t].voltageCode,
                expv(cfg, selPin[t]));
            chk("power", chanOut[t].powerEnable,
                cfg.outputEnable);
            chk("limsel", chanOut[t].limitSel, cfg.limitSel);
            chk("tx oe", chanOut[t].txIndicatorOe_n,
                !cfg.txModeBit);
            chk("static out", chanOut[t].staticLimitMode,
                cfg.staticLimitMode);
            chk("limit on", chanOut[t].currentLimitOn,
                cfg.staticLimitMode);
            apb(0, t ? ADDR_CTRL_CH2 : ADDR_CTRL_CH1, 0);
            chk("ctrl rd", rdq, 32'(cfg));
        end
        // tone source selection on channel one
        modPin[0] <= 1'b0;
        apb(1, ADDR_CTRL_CH1, 32'h3);
        tog(0, t); chk("tone cont", t >= 2, 1);
        apb(1, ADDR_CTRL_CH1, 32'h1);
        tog(0, t); chk("tone gated", t, 0);
        modPin[0] <= 1'b1;
        tog(0, t); chk("tone open", t >= 2, 1);
        apb(1, ADDR_CTRL_CH1, 32'h5);
        for (int i = 0; i < 6; i++) begin
            modPin[0] <= i[0];
            repeat (4) @(posedge clock);
            chk("ext tone", chanOut[0].toneOut, i[0]);
        end
        // dynamic overload and retry cycling
        apb(1, ADDR_CTRL_CH1, 32'h1);
        shortCmd[0] <= 1'b1;
        repeat (560) @(posedge clock);
        apb(0, ADDR_STATUS, 0); chk("ol early", rdq[1], 0);
        for (n = 0; n < 20 && rdq[1] !== 1'b1; n++) apb(0, ADDR_STATUS, 0);
        chk("ol flag", rdq[1], 1);
        chk("ol off", chanOut[0].powerEnable, 0);
        chk("ol fault", fault_n, 0);
        for (n = 0; n < 300 && chanOut[0].powerEnable !== 1'b1; n++)
            @(posedge clock);
        chk("off time", n > 150 && n < 300, 1);
        repeat (8) @(posedge clock);
        chk("retry off", chanOut[0].powerEnable, 0);
        shortCmd[0] <= 1'b0;
        for (n = 0; n < 300 && chanOut[0].powerEnable !== 1'b1; n++)
            @(posedge clock);
        repeat (60) @(posedge clock);
        apb(0, ADDR_STATUS, 0); chk("ol clear", rdq[1], 0);
        // static limiting never shuts off; start loads in static mode
        apb(1, ADDR_CTRL_CH1, 32'h81);
        shortCmd[0] <= 1'b1;
        repeat (700) @(posedge clock);
        chk("static on", chanOut[0].powerEnable, 1);
        chk("static lim", chanOut[0].currentLimitOn, 1);
        apb(0, ADDR_STATUS, 0); chk("static flag", rdq[1], 1);
        shortCmd[0] <= 1'b0;
        repeat (4) @(posedge clock);
        apb(0, ADDR_STATUS, 0); chk("static clr", rdq[1], 0);
        // back current on channel two
        apb(1, ADDR_CTRL_CH2, 32'h1);
        backfeedCmd[1] <= 1'b1;
        repeat (2400) @(posedge clock);
        apb(0, ADDR_STATUS, 0); chk("bc early", rdq[4], 0);
        for (n = 0; n < 100 && rdq[4] !== 1'b1; n++) apb(0, ADDR_STATUS, 0);
        chk("bc flag", rdq[4], 1);
        chk("bc off", chanOut[1].powerEnable, 0);
        for (n = 0; n < 100 && chanOut[1].powerEnable !== 1'b1; n++)
            @(posedge clock);
        chk("bc probe", n > 20 && n < 100, 1);
        backfeedCmd[1] <= 1'b0;
        repeat (3000) @(posedge clock);
        apb(0, ADDR_STATUS, 0); chk("bc clear", rdq[4], 0);
        chk("bc back", chanOut[1].powerEnable, 1);
        // over-temperature shuts both channels
        overTemp <= 1'b1;
        repeat (4) @(posedge clock);
        chk("hot off", {chanOut[0].powerEnable,
            chanOut[1].powerEnable}, 0);
        apb(0, ADDR_STATUS, 0); chk("hot flag", rdq[0], 1);
        overTemp <= 1'b0;
        repeat (4) @(posedge clock);
        apb(0, ADDR_STATUS, 0); chk("cool flag", rdq[0], 0);
        chk("cool on", chanOut[0].powerEnable, 1);
        chk("fault clear", fault_n, 1);
        // host rewrites the enables to the state it wants
        apb(1, ADDR_CTRL_CH1, 0);
        apb(1, ADDR_CTRL_CH2, 0);
        repeat (3) @(posedge clock);
        chk("fault off", fault_n, 0);
        apb(1, ADDR_CTRL_CH1, 32'h7FF);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        apb(0, ADDR_CTRL_CH1, 0); chk("ctrl re-rst", rdq, 0);
        end_sim();
    end
endmodule
